// ### sim/csd_core_model.sv
// Data-space master model that drives register requests
`timescale 1ns/10ps
`default_nettype none
module csd_core_model
  import csd_pkg::*;
(
  input wire logic core_clk,
  output var csd_bus_req_type busReq
);
  // ==========================================
  // Requests
  initial busReq = '{1'b0, 1'b0, 1'b0, 16'hFFFF, 16'hFFFF};
  // Strobes drop and address and data are inverted on release so a stale request never looks valid
  task automatic acc(input logic r, input logic w, input logic b, input logic [15:0] a,
    input logic [15:0] d);
    @(negedge core_clk);
    busReq <= '{r, w, b, a, d};
    @(negedge core_clk);
    busReq <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// ### sim/csd_sfr_decode_props.sv
// Checker for the core register space decode
`timescale 1ns/10ps
`default_nettype none
module csd_sfr_decode_props
  import csd_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire csd_bus_req_type busReq,
  input wire logic [15:0] rdData,
  input wire logic rdValid,
  input wire logic implHit,
  input wire logic addrError,
  input wire logic programViewEnable,
  input wire logic priorityLevelBit3,
  input wire logic [15:0] stackPointer
);
  // ==========================================
  // Request timing
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic rq;
  logic go;
  assign rq = clkEn && busReq.rdEn;
  assign go = clkEn && (busReq.rdEn || busReq.wrEn);
  a_read_pulse: assert property (rq |=> rdValid) else $error("rdValid");
  a_idle_quiet: assert property (clkEn && !busReq.rdEn |=> !rdValid && rdData == 16'h0000)
    else $error("idle");
  a_outside_zero: assert property (rq && busReq.addr > SFR_LAST_ADDR
    && busReq.addr[15:1] != 15'h4000 |=> rdData == 16'h0000) else $error("outside");
  a_block_hit: assert property (go |=> implHit == ($past(busReq.addr) <= SFR_LAST_ADDR
    && IMPL_BLOCK_MAP[$past(busReq.addr[10:5])])) else $error("implHit");
  a_odd_word: assert property (go && !busReq.byteMode && busReq.addr[0] |=> addrError)
    else $error("addrError");
  a_byte_upper: assert property (rq && busReq.byteMode |=> rdData[15:8] == 8'h00)
    else $error("byte");
  a_view_copy: assert property (clkEn && busReq.wrEn && busReq.addr == 16'h0044 ##1 clkEn
    |=> programViewEnable == $past(busReq.wrData[2], 2)) else $error("view");
  a_stack_reset: assert property ($rose(nrst) |-> stackPointer == 16'h0800)
    else $error("stack");
endmodule
bind csd_sfr_decode csd_sfr_decode_props u_props (.core_clk, .nrst, .clkEn, .busReq, .rdData,
  .rdValid, .implHit, .addrError, .programViewEnable, .priorityLevelBit3, .stackPointer);
`default_nettype wire

// ### sim/csd_sfr_decode_tb_top.sv
// Testbench for the core register space decode
`timescale 1ns/10ps
`default_nettype none
module csd_sfr_decode_tb_top
  import csd_pkg::*;
;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic clkEn = 1'b1;
  csd_bus_req_type busReq;
  logic [15:0] rdData;
  logic [15:0] stackPointer;
  logic rdValid, implHit, addrError, programViewEnable, priorityLevelBit3;
  int num_errors = 0;
  int checks = 0;
  csd_sfr_decode dut (.core_clk, .nrst, .clkEn, .busReq, .rdData, .rdValid, .implHit,
    .addrError, .programViewEnable, .priorityLevelBit3, .stackPointer);
  csd_core_model core (.core_clk, .busReq);
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic b, input logic [15:0] e);
    core.acc(1'b1, 1'b0, b, a, 16'h0000);
    chk("rdValid", {15'h0000, rdValid}, 16'h0001);
    chk("rdData", rdData, e);
  endtask
  task automatic rst();
    nrst = 1'b0;
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk("stackPointer", stackPointer, 16'h0800);
    // Core control copies must come out of reset low, not just follow a later write
    chk("view", {15'h0000, programViewEnable}, 16'h0000);
    chk("level", {15'h0000, priorityLevelBit3}, 16'h0000);
    for (int i = 0; i < NUM_REGS; i++)
      rd(REG_OFFSET[i], 1'b0, REG_RESET[i]);
    $display("t_reset end");
  endtask
  task automatic t_mask();
    for (int i = 0; i < NUM_REGS; i++)
      core.acc(1'b0, 1'b1, 1'b0, REG_OFFSET[i], 16'hFFFF);
    for (int i = 0; i < NUM_REGS; i++)
      rd(REG_OFFSET[i], 1'b0, REG_MASK[i]);
    chk("view", {15'h0000, programViewEnable}, 16'h0001);
    chk("level", {15'h0000, priorityLevelBit3}, 16'h0001);
    chk("stackPointer", stackPointer, 16'hFFFF);
    core.acc(1'b0, 1'b1, 1'b0, 16'h0034, 16'h1234);
    rd(16'h0034, 1'b0, 16'h0034);
    $display("t_mask end");
  endtask
  task automatic t_byte();
    core.acc(1'b0, 1'b1, 1'b1, 16'h0003, 16'h5A00);
    core.acc(1'b0, 1'b1, 1'b1, 16'h0004, 16'h0012);
    rd(16'h0002, 1'b0, 16'h00FF);
    rd(16'h0003, 1'b1, 16'h0000);
    rd(16'h0004, 1'b1, 16'h0012);
    core.acc(1'b0, 1'b1, 1'b0, 16'h0005, 16'h0000);
    chk("addrError", {15'h0000, addrError}, 16'h0001);
    rd(16'h0004, 1'b0, 16'hFF12);
    chk("addrError", {15'h0000, addrError}, 16'h0000);
    // Read and write in one cycle: the read sees the word from before the write
    core.acc(1'b1, 1'b1, 1'b0, 16'h0006, 16'h1234);
    chk("rdData", rdData, 16'hFFFF);
    rd(16'h0006, 1'b0, 16'h1234);
    // Odd word read still returns the word but flags the address
    core.acc(1'b1, 1'b0, 1'b0, 16'h0007, 16'h0000);
    chk("addrError", {15'h0000, addrError}, 16'h0001);
    chk("rdData", rdData, 16'h1234);
    $display("t_byte end");
  endtask
  task automatic t_space();
    logic [15:0] ad [4] = '{16'h0100, 16'h0008, 16'h0400, 16'h0800};
    logic [15:0] hit [4] = '{16'h0001, 16'h0001, 16'h0000, 16'h0000};
    for (int i = 0; i < 4; i++)
    begin
      core.acc(1'b0, 1'b1, 1'b0, ad[i], 16'hFFFF);
      rd(ad[i], 1'b0, 16'h0000);
      chk("implHit", {15'h0000, implHit}, hit[i]);
    end
    rd(16'h8000, 1'b0, 16'hFFFF);
    clkEn = 1'b0;
    core.acc(1'b0, 1'b1, 1'b0, 16'h0002, 16'h0000);
    clkEn = 1'b1;
    rd(16'h0002, 1'b0, 16'h00FF);
    $display("t_space end");
  endtask
  initial
  begin
    rst();
    t_reset();
    t_mask();
    t_byte();
    t_space();
    rst();
    t_reset();
    close_out();
  end
  initial
  begin
    #1000000;
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire

// ### verilog/csd_byte_reg.sv
// One 16-bit register with separate byte-lane write strobes
`timescale 1ns/10ps
`default_nettype none

module csd_byte_reg
  import csd_pkg::*;
#(
  parameter logic [15:0] RESET_VALUE = 16'h0000,
  parameter logic [15:0] WRITE_MASK = 16'hFFFF
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic [1:0] wrLane,
  input wire logic [15:0] wrData,
  output logic [15:0] value
);

  csd_breg_state_type state;
  csd_breg_state_type next_state;

  // ==========================================================================
  // Lane update
  always_comb
  begin
    next_state = state;
    if (clkEn)
    begin
      if (wrLane[0])
        next_state.value[7:0] = wrData[7:0] & WRITE_MASK[7:0];
      if (wrLane[1])
        next_state.value[15:8] = wrData[15:8] & WRITE_MASK[15:8];
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      state <= '{value: RESET_VALUE};
    else
      state <= next_state;
  end

  assign value = state.value;

endmodule

`default_nettype wire

// ### verilog/csd_pkg.sv
// Constants and types shared by the core register space decode
package csd_pkg;

  // ==========================================================================
  // Special function register space
  localparam logic [15:0] SFR_FIRST_ADDR = 16'h0000;
  localparam logic [15:0] SFR_LAST_ADDR = 16'h07FF;
  localparam int BLOCK_BYTES_LOG2 = 5;
  localparam int NUM_BLOCKS = 64;
  // One bit per 32-byte block, set where any register lives in the block
  localparam logic [63:0] IMPL_BLOCK_MAP = 64'h0C17_0000_03CF_177F;

  // ==========================================================================
  // Core register table, in table order
  localparam int NUM_REGS = 25;
  localparam int IDX_WORKING_15_STACK = 15;
  localparam int IDX_CORE_CONTROL = 22;

  localparam logic [15:0] REG_OFFSET [NUM_REGS] = '{
    16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h8000, 16'h000A, 16'h000C,
    16'h000E, 16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001A,
    16'h001C, 16'h001E, 16'h0020, 16'h002E, 16'h0030, 16'h0032, 16'h0034,
    16'h0036, 16'h0042, 16'h0044, 16'h0052};

  // Undefined reset contents are given a fixed zero so state is known
  localparam logic [15:0] REG_RESET [NUM_REGS] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0800, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000};

  // Implemented bits; the rest hold zero and read as zero
  localparam logic [15:0] REG_MASK [NUM_REGS] = '{
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h00FF, 16'h00FF, 16'h00FF,
    16'hFFFF, 16'h01FF, 16'h000C, 16'hFFFF};

  // ==========================================================================
  // Field positions
  localparam int CORE_CONTROL_PROGRAM_VIEW_ENABLE = 2;
  localparam int CORE_CONTROL_PRIORITY_LEVEL_BIT3 = 3;

  // ==========================================================================
  // Carriers and state
  typedef struct packed {
    logic rdEn;
    logic wrEn;
    logic byteMode;
    logic [15:0] addr;
    logic [15:0] wrData;
  } csd_bus_req_type;

  typedef struct packed {
    logic [15:0] value;
  } csd_breg_state_type;

  typedef struct packed {
    logic [15:0] rdData;
    logic rdValid;
    logic implHit;
    logic addrError;
    logic programViewEnable;
    logic priorityLevelBit3;
  } csd_top_state_type;

endpackage

// ### verilog/csd_sfr_decode.sv
// Core special function register bank and register space decode
`timescale 1ns/10ps
`default_nettype none

module csd_sfr_decode
  import csd_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire csd_bus_req_type busReq,
  output logic [15:0] rdData,
  output logic rdValid,
  output logic implHit,
  output logic addrError,
  output logic programViewEnable,
  output logic priorityLevelBit3,
  output logic [15:0] stackPointer
);

  csd_top_state_type state;
  csd_top_state_type next_state;
  logic [15:0] regValue [NUM_REGS];
  logic [NUM_REGS-1:0] regHit;
  logic [1:0] laneSel;
  logic [15:0] laneData;
  logic misaligned;
  logic inRegion;

  // ==========================================================================
  // Address decode
  always_comb
  begin
    for (int i = 0; i < NUM_REGS; i++)
      regHit[i] = (busReq.addr[15:1] == REG_OFFSET[i][15:1]);
    inRegion = (busReq.addr <= SFR_LAST_ADDR) && (busReq.addr >= SFR_FIRST_ADDR);
    misaligned = !busReq.byteMode && busReq.addr[0];
    if (!busReq.wrEn || misaligned)
      laneSel = 2'b00;
    else if (!busReq.byteMode)
      laneSel = 2'b11;
    else if (busReq.addr[0])
      laneSel = 2'b10;
    else
      laneSel = 2'b01;
    // Byte data arrives in the low byte and is steered to either lane
    if (busReq.byteMode)
      laneData = {busReq.wrData[7:0], busReq.wrData[7:0]};
    else
      laneData = busReq.wrData;
  end

  // ==========================================================================
  // Register instances
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++)
    begin : gen_reg
      csd_byte_reg #(
        .RESET_VALUE(REG_RESET[g]),
        .WRITE_MASK(REG_MASK[g])
      ) u_reg (
        .core_clk(core_clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .wrLane(regHit[g] ? laneSel : 2'b00),
        .wrData(laneData),
        .value(regValue[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Read path and status
  always_comb
  begin
    logic [15:0] word;
    word = 16'h0000;
    next_state = state;
    for (int i = 0; i < NUM_REGS; i++)
      if (regHit[i])
        word = word | (regValue[i] & REG_MASK[i]);
    if (clkEn)
    begin
      next_state.rdValid = busReq.rdEn;
      next_state.addrError = (busReq.rdEn || busReq.wrEn) && misaligned;
      next_state.implHit = inRegion
        && IMPL_BLOCK_MAP[busReq.addr[BLOCK_BYTES_LOG2 +: 6]];
      if (!busReq.rdEn)
        next_state.rdData = 16'h0000;
      else if (busReq.byteMode && busReq.addr[0])
        next_state.rdData = {8'h00, word[15:8]};
      else if (busReq.byteMode)
        next_state.rdData = {8'h00, word[7:0]};
      else
        next_state.rdData = word;
      // Core control bits mirrored so the outputs come from flops
      next_state.programViewEnable =
        regValue[IDX_CORE_CONTROL][CORE_CONTROL_PROGRAM_VIEW_ENABLE];
      next_state.priorityLevelBit3 =
        regValue[IDX_CORE_CONTROL][CORE_CONTROL_PRIORITY_LEVEL_BIT3];
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      state <= '0;
    else
      state <= next_state;
  end

  assign rdData = state.rdData;
  assign rdValid = state.rdValid;
  assign implHit = state.implHit;
  assign addrError = state.addrError;
  assign programViewEnable = state.programViewEnable;
  assign priorityLevelBit3 = state.priorityLevelBit3;
  assign stackPointer = regValue[IDX_WORKING_15_STACK];

endmodule

`default_nettype wire
